// >>> pkg/rcd_pkg.sv
`default_nettype none
package rcd_pkg;
  localparam int PC_W        = 10;
  localparam int IW          = 12;
  localparam int DW          = 8;
  localparam int PINS        = 6;
  localparam int CYC_NS_REF  = 1000;
  localparam int REF_MHZ     = 4;
  localparam int CYC_CLKS    = CYC_NS_REF * REF_MHZ / 1000;
  localparam logic [11:0] NOP_OP   = 12'h000;
  localparam logic [4:0]  A_IND    = 5'h00;
  localparam logic [4:0]  A_TMR    = 5'h01;
  localparam logic [4:0]  A_PCL    = 5'h02;
  localparam logic [4:0]  A_STAT   = 5'h03;
  localparam logic [4:0]  A_FSR    = 5'h04;
  localparam logic [4:0]  A_PORT   = 5'h06;
  localparam int ST_C        = 0;
  localparam int ST_DC       = 1;
  localparam int ST_Z        = 2;
  localparam int OPT_TCS     = 5;
  localparam int OPT_PULL_N  = 6;
  localparam int OPT_WAKE_N  = 7;
  localparam logic [7:0]  STAT_RST = 8'h18;
  localparam logic [7:0]  OPT_RST  = 8'hff;
  localparam logic [5:0]  DIR_RST  = 6'h3f;
  localparam logic [9:0]  PC_RST   = 10'h3ff;
  localparam logic [3:0]  WB_CFG   = 4'h0;
  localparam logic [3:0]  WB_CORE  = 4'h4;
  localparam logic [3:0]  WB_PINS  = 4'h8;
  localparam int CFG_MASTER_CLEAR_N    = 2;
  localparam int CFG_PROG    = 3;
  localparam logic [3:0]  CFG_RST  = 4'h2;
  typedef enum logic [1:0] {
    OSC_LP    = 2'b00,
    OSC_XT    = 2'b01,
    OSC_INTRC = 2'b10,
    OSC_EXTRC = 2'b11
  } rcd_osc_e;
  typedef enum logic {RUN = 1'b0, SLEEP = 1'b1} rcd_run_e;
  typedef struct packed {
    logic       c;
    logic       dc;
    logic [7:0] v;
  } rcd_alu_s;
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pull;
  } rcd_pin_s;
endpackage : rcd_pkg
`default_nettype wire

// >>> verilog/rcd_core.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module rcd_core (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output logic      [rcd_pkg::PC_W-1:0] pmem_addr_o,
  input  wire logic [rcd_pkg::IW-1:0]   pmem_data_i,
  input  wire logic [5:0]          pin_i,
  output var rcd_pkg::rcd_pin_s    pins_o,
  output logic                     schmitt_o,
  output logic                     sleeping_o
);
  import rcd_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic [1:0]  ph_r;
  logic [5:0]  s1_r, s2_r;
  logic [3:0]  cfg_r;
  logic [9:0]  pc_r, stk0_r, stk1_r;
  logic [11:0] ir_r;
  logic [7:0]  w_r, stat_r, fsr_r, opt_r, tmr_r;
  logic [5:0]  dir_r, lat_r, wake_ref_r;
  logic        t2_r, flush_r;
  logic [7:0]  ram_r [0:31];
  rcd_run_e    run_r;
  rcd_osc_e    osc;

  // Phase pulses
  // four phase divider
  wire q1 = (ph_r == 2'd0);
  wire q4 = (ph_r == 2'(CYC_CLKS - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) ph_r <= 2'd0;
    else ph_r <= ph_r + 2'd1;
  end

  // Only s2_r is looked at
  always_ff @(posedge clk_i) begin
    s1_r <= pin_i;
    s2_r <= s1_r;
  end

  assign osc = rcd_osc_e'(cfg_r[1:0]);
  wire master_clear_n_hit = cfg_r[CFG_MASTER_CLEAR_N] & ~s2_r[3];
  wire core_rst = rst_i | master_clear_n_hit;
  wire run = (run_r == RUN);
  wire ex = q4 & run;

  ////////////////////////////////////////////////////////////////////
  // Operand fetch
  // indirect through pointer
  wire [4:0] fa = (ir_r[4:0] == A_IND) ? fsr_r[4:0] : ir_r[4:0];
  // Counter runs two words ahead of the executing word
  wire [9:0] pc_ex = pc_r - 10'd1;
  logic [7:0] fv;
  always_comb begin
    fv = ram_r[fa];
    case (fa)
      A_IND:  fv = 8'h00;
      A_TMR:  fv = tmr_r;
      A_PCL:  fv = pc_ex[7:0];
      A_STAT: fv = stat_r;
      A_FSR:  fv = fsr_r;
      A_PORT: fv = {2'b00, s2_r};
      default: fv = ram_r[fa];
    endcase
  end

  function automatic rcd_alu_s add8(input logic [7:0] a, input logic [7:0] b,
                                    input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return '{c: s[8], dc: n[4], v: s[7:0]};
  endfunction : add8

  ////////////////////////////////////////////////////////////////////
  // Decode and ALU
  wire [1:0] grp = ir_r[11:10];
  wire [3:0] sub = ir_r[9:6];
  wire [7:0] k8 = ir_r[7:0];
  wire [7:0] bm = 8'h01 << ir_r[7:5];
  wire rcd_alu_s sum = add8(fv, w_r, 1'b0);
  wire rcd_alu_s dif = add8(fv, ~w_r, 1'b1);
  logic [7:0] res;
  logic wf, ww, uz, uc, udc, cn, dcn, skp, jmp, psh, pop, slp, wo, wd;
  logic [9:0] jpc;
  // working register with file or literal
  always_comb begin
    res = fv; wf = 1'b0; ww = 1'b0; uz = 1'b0; uc = 1'b0; udc = 1'b0;
    cn = stat_r[ST_C]; dcn = stat_r[ST_DC]; skp = 1'b0; jmp = 1'b0;
    psh = 1'b0; pop = 1'b0; slp = 1'b0; wo = 1'b0; wd = 1'b0;
    jpc = pc_r;
    if (grp == 2'b00) begin
      wf = ir_r[5];
      ww = ~ir_r[5];
      uz = 1'b1;
      unique case (sub)
        4'h0: begin
          uz = 1'b0; ww = 1'b0; res = w_r;
          slp = (ir_r[5:0] == 6'h03);
          wo = (ir_r[5:0] == 6'h02);
          wd = (ir_r[5:0] == 6'h06);
        end
        4'h1: res = 8'h00;
        4'h2: begin res = dif.v; uc = 1'b1; udc = 1'b1;
          cn = dif.c; dcn = dif.dc; end
        4'h3, 4'hb: res = fv - 8'h01;
        4'h4: res = fv | w_r;
        4'h5: res = fv & w_r;
        4'h6: res = fv ^ w_r;
        4'h7: begin res = sum.v; uc = 1'b1; udc = 1'b1;
          cn = sum.c; dcn = sum.dc; end
        4'h8: res = fv;
        4'h9: res = ~fv;
        4'ha, 4'hf: res = fv + 8'h01;
        4'hc: begin res = {stat_r[ST_C], fv[7:1]}; uc = 1'b1;
          cn = fv[0]; end
        4'hd: begin res = {fv[6:0], stat_r[ST_C]}; uc = 1'b1;
          cn = fv[7]; end
        4'he: res = {fv[3:0], fv[7:4]};
      endcase
      if (sub == 4'hb || sub == 4'hf || sub >= 4'hc) uz = 1'b0;
      skp = (sub == 4'hb || sub == 4'hf) && (res == 8'h00);
    end else if (grp == 2'b01) begin
      unique case (ir_r[9:8])
        2'b00: begin res = fv & ~bm; wf = 1'b1; end
        2'b01: begin res = fv | bm; wf = 1'b1; end
        2'b10: skp = ((fv & bm) == 8'h00);
        2'b11: skp = ((fv & bm) != 8'h00);
      endcase
    end else if (grp == 2'b10) begin
      jmp = 1'b1;
      unique case (ir_r[9:8])
        2'b00: begin res = k8; ww = 1'b1; pop = 1'b1; jpc = stk0_r; end
        2'b01: begin psh = 1'b1; jpc = {2'b00, k8}; end
        default: jpc = {1'b0, ir_r[8:0]};
      endcase
    end else begin
      ww = 1'b1;
      uz = (ir_r[9:8] != 2'b00);
      unique case (ir_r[9:8])
        2'b00: res = k8;
        2'b01: res = k8 | w_r;
        2'b10: res = k8 & w_r;
        2'b11: res = k8 ^ w_r;
      endcase
    end
    if (wf && fa == A_PCL) begin
      jmp = 1'b1;
      jpc = {pc_ex[9], 1'b0, res};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Execute and fetch
  wire [7:0] st_w = (wf && fa == A_STAT) ? res : stat_r;
  wire z_nx = uz ? (res == 8'h00) : st_w[ST_Z];
  wire [7:0] stat_nxt = {st_w[7:3], z_nx, udc ? dcn : st_w[ST_DC],
                         uc ? cn : st_w[ST_C]};
  wire t2_rise = s2_r[2] & ~t2_r;
  wire tmr_tick = opt_r[OPT_TCS] ? t2_rise : q4;
  wire wake = ~opt_r[OPT_WAKE_N] &&
              ({s2_r[3], s2_r[1:0]} != {wake_ref_r[3], wake_ref_r[1:0]});
  wire do_ex = ex & ~flush_r;

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      pc_r <= PC_RST; pmem_addr_o <= PC_RST; ir_r <= NOP_OP;
      flush_r <= 1'b1; w_r <= 8'h00; stat_r <= STAT_RST;
      fsr_r <= 8'h00; opt_r <= OPT_RST; dir_r <= DIR_RST;
      lat_r <= 6'h00; stk0_r <= 10'h000; stk1_r <= 10'h000;
      run_r <= RUN; wake_ref_r <= 6'h00;
    end else begin
      if (q1 && run) begin
        pmem_addr_o <= pc_r;
        pc_r <= pc_r + 10'd1;
      end
      if (ex) begin
        ir_r <= pmem_data_i;
        flush_r <= 1'b0;
      end
      if (do_ex) begin
        stat_r <= stat_nxt;
        if (ww) w_r <= res;
        if (wf && fa == A_FSR) fsr_r <= res;
        if (wf && fa == A_PORT) lat_r <= res[5:0];
        if (wo) opt_r <= w_r;
        if (wd) dir_r <= w_r[5:0];
        if (jmp || skp) flush_r <= 1'b1;
        if (jmp) pc_r <= jpc;
        if (psh) begin
          stk0_r <= pc_ex;
          stk1_r <= stk0_r;
        end
        if (pop) stk0_r <= stk1_r;
        if (slp) begin
          run_r <= SLEEP;
          wake_ref_r <= s2_r;
        end
      end
      if (run_r == SLEEP && wake) run_r <= RUN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_ex && wf && fa > A_PORT) ram_r[fa] <= res;
  end

  always_ff @(posedge clk_i) begin
    t2_r <= s2_r[2];
    if (core_rst) tmr_r <= 8'h00;
    else if (do_ex && wf && fa == A_TMR) tmr_r <= res;
    else if (tmr_tick) tmr_r <= tmr_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////
  // Pin functions
  wire xtal = (osc == OSC_XT) || (osc == OSC_LP);
  wire [5:0] gp_en = {osc == OSC_INTRC, ~xtal, 1'b0,
                      ~opt_r[OPT_TCS], 2'b11};
  wire pu = ~opt_r[OPT_PULL_N];
  rcd_pin_s pins_nxt;
  wire [5:0] oe_nxt = gp_en & ~dir_r;
  wire [5:0] pull_nxt = {2'b00, pu | cfg_r[CFG_MASTER_CLEAR_N], 1'b0, pu, pu};
  assign pins_nxt = '{out: lat_r, oe: oe_nxt, pull: pull_nxt};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_o <= '0;
      schmitt_o <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      pins_o <= pins_nxt;
      schmitt_o <= cfg_r[CFG_PROG];
      sleeping_o <= (run_r == SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wcfg = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == WB_CFG);
  wire [31:0] rd_core = {5'h00, run_r == SLEEP, pc_r, stat_r, w_r};
  wire [31:0] rd_pins = {10'h000, pins_o.oe, 2'b00, pins_o.out, 2'b00, s2_r};
  wire [31:0] rd_mux = (wb_adr_i == WB_CFG)  ? {28'h0000000, cfg_r} :
                       (wb_adr_i == WB_CORE) ? rd_core :
                       (wb_adr_i == WB_PINS) ? rd_pins : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) wb_dat_o <= rd_mux;
      if (wb_wcfg) cfg_r <= wb_dat_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  phase_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q1 |=> !q1 [*3] ##1 q1) else $error("phase period wrong");
  word_latch_a: assert property (@(posedge clk_i) disable iff (core_rst)
    ex |=> ir_r == $past(pmem_data_i)) else $error("fetch word lost");
  fetch_addr_a: assert property (@(posedge clk_i) disable iff (core_rst)
    (q1 && run) |=> pmem_addr_o == pc_r - 10'd1) else $error("fetch address");
  flush_br_a: assert property (@(posedge clk_i) disable iff (core_rst)
    (do_ex && jmp) |=> flush_r ##3 !do_ex) else $error("prefetch kept");
  zero_flag_a: assert property (@(posedge clk_i) disable iff (core_rst)
    (do_ex && uz) |=> stat_r[ST_Z] == ($past(res) == 8'h00))
    else $error("zero flag");
  sub_borrow_a: assert property (@(posedge clk_i) disable iff (core_rst)
    (do_ex && grp == 2'b00 && sub == 4'h2 && !(wf && fa == A_STAT)) |=>
    stat_r[ST_C] == ($past(fv) >= $past(w_r))) else $error("borrow");
  master_clear_n_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    master_clear_n_hit |=> pc_r == PC_RST && ir_r == NOP_OP) else $error("master_clear_n");
  xtal_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    xtal |=> !pins_o.oe[4]) else $error("pin 4 driven");
  osc_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (osc != OSC_INTRC) |=> !pins_o.oe[5]) else $error("pin 5 driven");
  master_clear_n_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_r[CFG_MASTER_CLEAR_N] |=> pins_o.pull[3] && !pins_o.oe[3]) else $error("pull");
  prog_st_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_r[CFG_PROG] |=> schmitt_o) else $error("schmitt");
  w_write_a: assert property (@(posedge clk_i) disable iff (core_rst)
    (do_ex && ww) |=> w_r == $past(res)) else $error("working register");
  pin3_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pins_o.oe[3]) else $error("pin 3 driven");
  call_push_a: assert property (@(posedge clk_i) disable iff (core_rst)
    (do_ex && psh) |=> stk0_r == $past(pmem_addr_o)) else $error("return address");
endmodule : rcd_core
`default_nettype wire

// >>> dv/rcd_pmem_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module rcd_pmem_model (
  input  wire logic [rcd_pkg::PC_W-1:0] addr_i,
  output logic      [rcd_pkg::IW-1:0]   data_o
);
  import rcd_pkg::*;
  logic [IW-1:0] mem [0:1023];
  // Unused words run as no-ops, never as unknowns
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = NOP_OP;
    end
  end
  // whole word per address
  // Combinational read, settled long before the latch edge
  assign data_o = mem[addr_i];
endmodule : rcd_pmem_model
`default_nettype wire

// >>> dv/risc_core_datapath_pins_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module risc_core_datapath_pins_tb_top;
  import rcd_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic [9:0]  paddr;
  logic [11:0] pdata;
  logic [5:0]  pin;
  rcd_pin_s    pins;
  logic        schm;
  logic        slp;
  int          n_mismatch = 0;
  int          checked = 0;
  ////////////////////////////////////////////////////////////////////////
  rcd_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pmem_addr_o(paddr), .pmem_data_i(pdata), .pin_i(pin),
    .pins_o(pins), .schmitt_o(schm), .sleeping_o(slp));
  rcd_pmem_model u_pmem (.addr_i(paddr), .data_o(pdata));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Waits for ack with no assumed latency
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 64) chk("wb_ack", 32'h1, 32'h0);
  endtask : wb
  // Program loaded under reset so no stale word is fetched
  task automatic run(input logic [59:0] p);
    rst_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      u_pmem.mem[i] = p[59-12*i -: 12];
    end
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (80) @(posedge clk_i);
  endtask : run
  task automatic alu_case(input logic [7:0] a, input logic [7:0] b, input logic [11:0] op,
                          input logic [7:0] ew, input logic [2:0] ef);
    int c;
    c = 0;
    run({4'hc, a, 12'h027, 4'hc, b, op, 12'ha04});
    wb(1'b0, WB_CORE, 32'h0);
    chk("w_reg", {24'h0, ew}, {24'h0, rd[7:0]});
    chk("flags", {29'h0, ef}, {29'h0, rd[10:8]});
    repeat (32) begin
      @(posedge clk_i);
      if (paddr === 10'h004) c++;
    end
    // Jump loop fetches 4 then discarded 5, four clocks each
    chk("fetch_loop", 32'd16, c);
  endtask : alu_case
  task automatic pin_case(input logic [7:0] opt, input logic [3:0] cfg,
                          input logic [5:0] eoe, input logic [5:0] epu);
    run({12'hc00, 12'h006, 4'hc, opt, 12'h002, 12'ha04});
    wb(1'b1, WB_CFG, {28'h0, cfg});
    repeat (4) @(posedge clk_i);
    chk("pin_oe", {26'h0, eoe}, {26'h0, pins.oe});
    chk("pin_pull", {26'h0, epu}, {26'h0, pins.pull});
    chk("schmitt", {31'h0, cfg[CFG_PROG]}, {31'h0, schm});
  endtask : pin_case
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    rst_i = 1'b1;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 4'h0;
    wdat  = 32'h0;
    pin   = 6'h3f;
    rd    = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, WB_CFG, 32'h0);
    chk("cfg_rst", {28'h0, CFG_RST}, {28'h0, rd[3:0]});
    wb(1'b1, 4'hc, 32'hffff_ffff);
    wb(1'b0, 4'hc, 32'h0);
    chk("unmapped", 32'h0, rd);
    alu_case(8'h0f, 8'h01, 12'h1c7, 8'h10, 3'b010);
    alu_case(8'h01, 8'hff, 12'h1c7, 8'h00, 3'b111);
    alu_case(8'h10, 8'h10, 12'h087, 8'h00, 3'b111);
    alu_case(8'h01, 8'h02, 12'h087, 8'hff, 3'b000);
    alu_case(8'h20, 8'h01, 12'h087, 8'h1f, 3'b001);
    alu_case(8'hf0, 8'h0f, 12'h147, 8'h00, 3'b100);
    alu_case(8'h03, 8'h55, 12'h307, 8'h01, 3'b001);
    // Call, return with literal, then or literal into the returned value
    run({12'h903, 12'hd20, 12'ha02, 12'h805, 12'h000});
    wb(1'b0, WB_CORE, 32'h0);
    chk("call_ret", 32'h25, {24'h0, rd[7:0]});
    // Sleep with wake enabled, then a change on pin 0 resumes the core
    run({12'hc1f, 12'h002, 12'h003, 12'hc2d, 12'h026});
    chk("sleeping", 32'h1, {31'h0, slp});
    pin <= 6'h3e;
    repeat (40) @(posedge clk_i);
    wb(1'b0, WB_CORE, 32'h0);
    chk("wake_w", 32'h2d, {24'h0, rd[7:0]});
    chk("awake", 32'h0, {31'h0, slp});
    chk("port_out", 32'h2d, {26'h0, pins.out});
    pin <= 6'h3f;
    pin_case(8'h1f, 4'h2, 6'b110111, 6'b001011);
    pin_case(8'h1f, 4'h4, 6'b000111, 6'b001011);
    pin_case(8'h1f, 4'h9, 6'b000111, 6'b001011);
    pin_case(8'h3f, 4'h3, 6'b010011, 6'b001011);
    pin_case(8'hdf, 4'h6, 6'b110111, 6'b001000);
    pin <= 6'h2a;
    repeat (8) @(posedge clk_i);
    wb(1'b0, WB_PINS, 32'h0);
    chk("pin_in", 32'h2a, {26'h0, rd[5:0]});
    pin <= 6'h37;
    repeat (8) @(posedge clk_i);
    // Low master clear pin holds the core at its reset vector
    chk("master_clear_n_hold", 32'h3ff, {22'h0, paddr});
    print_verdict;
  end
endmodule : risc_core_datapath_pins_tb_top
`default_nettype wire
